// ==== rtl/aaao_core.sv ====
`timescale 1ns/100ps
module aaao_core
	import aaao_pkg::*;
(
	input aaao_pkg::aaao_opcode_t opcode,
	input wire logic [aaao_pkg::DATA_W-1:0] dest_val,
	input wire logic [aaao_pkg::DATA_W-1:0] signed_source_operand,
	output logic [aaao_pkg::DATA_W-1:0] result,
	output logic zero_out,
	output logic carry_out,
	output logic op_known
);
	import aaao_pkg::*;

	// ----------------------------------------------------------------
	// Shared arithmetic terms
	// ----------------------------------------------------------------
	// One magnitude term feeds three opcodes so its negator is shared; a second negator forms the negated magnitude.
	logic src_neg;
	logic [DATA_W-1:0] magnitude_destination;
	logic [DATA_W-1:0] negated_destination;
	logic [DATA_W:0] plain_sum;
	logic [DATA_W:0] mag_sum;
	logic signed_ovf;
	logic src_zero;

	assign src_neg = signed_source_operand[DATA_W-1];
	// The most negative value negates to itself, so it passes unchanged.
	assign magnitude_destination = src_neg ? (~signed_source_operand + 1'b1)
		: signed_source_operand;
	assign negated_destination = ~magnitude_destination + 1'b1;
	assign plain_sum = {1'b0, dest_val} + {1'b0, signed_source_operand};
	assign mag_sum = {1'b0, dest_val} + {1'b0, magnitude_destination};
	assign signed_ovf = (dest_val[DATA_W-1] == signed_source_operand[DATA_W-1])
		&& (plain_sum[DATA_W-1] != dest_val[DATA_W-1]);
	assign src_zero = (signed_source_operand == DATA_RST);

	// ----------------------------------------------------------------
	// Result and flag selection by opcode
	// ----------------------------------------------------------------
	always_comb begin
		result = DATA_RST;
		zero_out = 1'b0;
		carry_out = 1'b0;
		op_known = 1'b1;
		case (opcode)
			AAAO_OP_MAG: begin
				result = magnitude_destination;
				zero_out = src_zero;
				carry_out = src_neg;
			end
			AAAO_OP_NEG_MAG: begin
				result = negated_destination;
				zero_out = src_zero;
				carry_out = src_neg;
			end
			AAAO_OP_SUM: begin
				result = plain_sum[DATA_W-1:0];
				zero_out = (plain_sum[DATA_W-1:0] == DATA_RST);
				carry_out = plain_sum[DATA_W];
			end
			AAAO_OP_SUM_MAG: begin
				result = mag_sum[DATA_W-1:0];
				zero_out = (mag_sum[DATA_W-1:0] == DATA_RST);
				// A negative source reports the inverted carry of the sum.
				carry_out = src_neg ? ~mag_sum[DATA_W] : mag_sum[DATA_W];
			end
			AAAO_OP_SIGNED_SUM: begin
				result = plain_sum[DATA_W-1:0];
				zero_out = (plain_sum[DATA_W-1:0] == DATA_RST);
				carry_out = signed_ovf;
			end
			default: begin
				op_known = 1'b0;
			end
		endcase
	end

endmodule

// ==== rtl/aaao_pkg.sv ====
package aaao_pkg;

	// ----------------------------------------------------------------
	// Data widths and instruction fields
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 9;
	localparam int unsigned IMM_W = 9;
	localparam int unsigned OPC_W = 6;
	localparam int unsigned OPC_LSB = 26;
	localparam int unsigned ZQ_BIT = 25;
	localparam int unsigned CQ_BIT = 24;
	localparam int unsigned RQ_BIT = 23;
	localparam int unsigned IQ_BIT = 22;
	localparam int unsigned DEST_LSB = 9;
	localparam int unsigned SRC_LSB = 0;

	// ----------------------------------------------------------------
	// Primary opcodes handled by this datapath
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		AAAO_OP_SUM = 6'b100000,
		AAAO_OP_SUM_MAG = 6'b100010,
		AAAO_OP_MAG = 6'b101010,
		AAAO_OP_NEG_MAG = 6'b101011,
		AAAO_OP_SIGNED_SUM = 6'b110100
	} aaao_opcode_t;

	// ----------------------------------------------------------------
	// APB register map, byte addresses
	// ----------------------------------------------------------------
	localparam int unsigned PADDR_W = 8;
	localparam logic [7:0] REG_INSTR = 8'h00;
	localparam logic [7:0] REG_DEST_OPND = 8'h04;
	localparam logic [7:0] REG_SRC_OPND = 8'h08;
	localparam logic [7:0] REG_RESULT = 8'h0C;
	localparam logic [7:0] REG_FLAGS = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_WB_ADDR = 8'h18;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_Z_BIT = 0;
	localparam int unsigned FLAG_C_BIT = 1;
	localparam int unsigned ST_WROTE_BIT = 0;
	localparam int unsigned ST_BADOP_BIT = 1;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [8:0] ADDR_RST = 9'h000;

endpackage

// ==== rtl/aaao_top.sv ====
`timescale 1ns/100ps
module aaao_top
	import aaao_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [aaao_pkg::PADDR_W-1:0] paddr,
	input wire logic [aaao_pkg::DATA_W-1:0] pwdata,
	output logic [aaao_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic wb_valid,
	output logic [aaao_pkg::ADDR_W-1:0] wb_addr,
	output logic [aaao_pkg::DATA_W-1:0] wb_data,
	output logic zero_flag,
	output logic carry_flag
);
	import aaao_pkg::*;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// Address match is used by both the write and the read decode.
	function automatic logic addr_is(input logic [PADDR_W-1:0] a, input logic [PADDR_W-1:0] r);
		addr_is = (a == r);
	endfunction

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] dest_opnd_q;
	logic [DATA_W-1:0] dest_opnd_d;
	logic [DATA_W-1:0] src_opnd_q;
	logic [DATA_W-1:0] src_opnd_d;
	logic [DATA_W-1:0] result_q;
	logic [DATA_W-1:0] result_d;
	logic zero_q;
	logic zero_d;
	logic carry_q;
	logic carry_d;
	logic wrote_q;
	logic wrote_d;
	logic badop_q;
	logic badop_d;
	logic [ADDR_W-1:0] wb_addr_q;
	logic [ADDR_W-1:0] wb_addr_d;
	logic wb_valid_q;
	logic wb_valid_d;
	logic [DATA_W-1:0] prdata_q;
	logic [DATA_W-1:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;

	// ----------------------------------------------------------------
	// APB phase decode
	// ----------------------------------------------------------------
	// One wait state: the first access cycle prepares read data and the
	// error answer, the second completes the transfer.
	logic acc_first;
	logic acc_done;
	logic wr_done;
	logic hit_instr;
	logic hit_dest;
	logic hit_src;
	logic hit_result;
	logic hit_flags;
	logic hit_status;
	logic hit_wbaddr;
	logic hit_any;
	logic hit_ro;

	assign acc_first = psel && penable && !pready_q;
	assign acc_done = psel && penable && pready_q;
	assign wr_done = acc_done && pwrite && !pslverr_q;
	assign hit_instr = addr_is(paddr, REG_INSTR);
	assign hit_dest = addr_is(paddr, REG_DEST_OPND);
	assign hit_src = addr_is(paddr, REG_SRC_OPND);
	assign hit_result = addr_is(paddr, REG_RESULT);
	assign hit_flags = addr_is(paddr, REG_FLAGS);
	assign hit_status = addr_is(paddr, REG_STATUS);
	assign hit_wbaddr = addr_is(paddr, REG_WB_ADDR);
	assign hit_any = hit_instr || hit_dest || hit_src || hit_result
		|| hit_flags || hit_status || hit_wbaddr;
	assign hit_ro = hit_result || hit_wbaddr;

	// ----------------------------------------------------------------
	// Instruction field extraction
	// ----------------------------------------------------------------
	// The instruction word is taken straight from the write data; it is
	// executed at the edge that completes the write to the launch register.
	aaao_opcode_t opcode;
	logic update_zero_qualifier;
	logic update_carry_qualifier;
	logic suppress_result_qualifier;
	logic imm_sel;
	logic [3:0] effect_and_immediate_bits;
	logic [ADDR_W-1:0] dest_field;
	logic [IMM_W-1:0] src_field;
	logic [DATA_W-1:0] src_value;
	logic launch;

	assign opcode = aaao_opcode_t'(pwdata[OPC_LSB +: OPC_W]);
	assign effect_and_immediate_bits = pwdata[IQ_BIT +: 4];
	assign update_zero_qualifier = effect_and_immediate_bits[ZQ_BIT-IQ_BIT];
	assign update_carry_qualifier = effect_and_immediate_bits[CQ_BIT-IQ_BIT];
	// A clear R bit is the suppress-result qualifier.
	assign suppress_result_qualifier = !effect_and_immediate_bits[RQ_BIT-IQ_BIT];
	assign imm_sel = effect_and_immediate_bits[0];
	assign dest_field = pwdata[DEST_LSB +: ADDR_W];
	assign src_field = pwdata[SRC_LSB +: IMM_W];
	// Immediates are zero-extended, so they can never look negative.
	assign src_value = imm_sel ? {{(DATA_W-IMM_W){1'b0}}, src_field}
		: src_opnd_q;
	assign launch = wr_done && hit_instr;

	// ----------------------------------------------------------------
	// Arithmetic core
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] alu_result;
	logic alu_zero;
	logic alu_carry;
	logic alu_known;

	aaao_core u_core (
		.opcode(opcode),
		.dest_val(dest_opnd_q),
		.signed_source_operand(src_value),
		.result(alu_result),
		.zero_out(alu_zero),
		.carry_out(alu_carry),
		.op_known(alu_known)
	);

	// ----------------------------------------------------------------
	// Execute and write-back next state
	// ----------------------------------------------------------------
	logic exec_ok;
	logic do_write;

	assign exec_ok = launch && alu_known;
	assign do_write = exec_ok && !suppress_result_qualifier;

	// The destination operand register stands in for the register file
	// entry, so a written result also becomes the next destination value.
	assign dest_opnd_d = do_write ? alu_result
		: ((wr_done && hit_dest) ? pwdata : dest_opnd_q);
	assign src_opnd_d = (wr_done && hit_src) ? pwdata : src_opnd_q;
	assign result_d = do_write ? alu_result : result_q;
	assign wb_valid_d = do_write;
	assign wb_addr_d = do_write ? dest_field : wb_addr_q;

	// Flags move only under their own qualifier; software may preset them.
	assign zero_d = (exec_ok && update_zero_qualifier) ? alu_zero
		: ((wr_done && hit_flags) ? pwdata[FLAG_Z_BIT] : zero_q);
	assign carry_d = (exec_ok && update_carry_qualifier) ? alu_carry
		: ((wr_done && hit_flags) ? pwdata[FLAG_C_BIT] : carry_q);

	// Status bits are sticky; a write of one clears, but a set wins.
	assign wrote_d = do_write
		|| (wrote_q && !(wr_done && hit_status && pwdata[ST_WROTE_BIT]));
	assign badop_d = (launch && !alu_known)
		|| (badop_q && !(wr_done && hit_status && pwdata[ST_BADOP_BIT]));

	// ----------------------------------------------------------------
	// APB answer next state
	// ----------------------------------------------------------------
	// Writes to read-only or unmapped words are refused with an error.
	logic [DATA_W-1:0] rd_mux;

	assign rd_mux = hit_instr ? DATA_RST
		: hit_dest ? dest_opnd_q
		: hit_src ? src_opnd_q
		: hit_result ? result_q
		: hit_flags ? {{(DATA_W-2){1'b0}}, carry_q, zero_q}
		: hit_status ? {{(DATA_W-2){1'b0}}, badop_q, wrote_q}
		: hit_wbaddr ? {{(DATA_W-ADDR_W){1'b0}}, wb_addr_q}
		: DATA_RST;
	assign pready_d = acc_first;
	assign pslverr_d = acc_first && (!hit_any || (pwrite && hit_ro));
	assign prdata_d = (acc_first && !pwrite) ? rd_mux : DATA_RST;

	// ----------------------------------------------------------------
	// Datapath registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			dest_opnd_q <= DATA_RST;
			src_opnd_q <= DATA_RST;
			result_q <= DATA_RST;
			wb_addr_q <= ADDR_RST;
			wb_valid_q <= 1'b0;
		end else begin
			dest_opnd_q <= dest_opnd_d;
			src_opnd_q <= src_opnd_d;
			result_q <= result_d;
			wb_addr_q <= wb_addr_d;
			wb_valid_q <= wb_valid_d;
		end
	end

	// ----------------------------------------------------------------
	// Flag and status registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			zero_q <= 1'b0;
			carry_q <= 1'b0;
			wrote_q <= 1'b0;
			badop_q <= 1'b0;
		end else begin
			zero_q <= zero_d;
			carry_q <= carry_d;
			wrote_q <= wrote_d;
			badop_q <= badop_d;
		end
	end

	// ----------------------------------------------------------------
	// APB answer registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_q <= DATA_RST;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign wb_valid = wb_valid_q;
	assign wb_addr = wb_addr_q;
	assign wb_data = result_q;
	assign zero_flag = zero_q;
	assign carry_flag = carry_q;

endmodule

// ==== verification/aaao_rf_model.sv ====
`timescale 1ns/100ps
module aaao_rf_model
	import aaao_pkg::*;
(
	input wire logic clk,
	input wire logic wb_valid,
	input wire logic [aaao_pkg::ADDR_W-1:0] wb_addr,
	input wire logic [aaao_pkg::DATA_W-1:0] wb_data
);
	// ----------------------------------------------------------------
	// Register file behind the write-back port
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem [2**ADDR_W];
	// Only a write-back pulse may change an entry, so stray pulses show up.
	always @(posedge clk) begin
		if (wb_valid) begin
			mem[wb_addr] <= wb_data;
		end
	end
endmodule

// ==== verification/aaao_top_sva.sv ====
`timescale 1ns/100ps
module aaao_top_sva
	import aaao_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [aaao_pkg::PADDR_W-1:0] paddr,
	input wire logic [aaao_pkg::DATA_W-1:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic wb_valid,
	input wire logic [aaao_pkg::DATA_W-1:0] wb_data,
	input wire logic zero_flag,
	input wire logic carry_flag
);
	// ----------------------------------------------------------------
	// Instruction launched one cycle back
	// ----------------------------------------------------------------
	logic exec_q;
	logic exec_d;
	logic [31:0] instr_q;
	logic [31:0] imm_x;
	logic imm_q;
	logic mag_q;
	// The launch is latched so that flags and write-back can be tied to it.
	assign exec_d = psel && penable && pready && pwrite && !pslverr && paddr == REG_INSTR;
	assign imm_x = {23'h00_0000, instr_q[8:0]};
	assign imm_q = exec_q && instr_q[IQ_BIT];
	assign mag_q = instr_q[31:26] == AAAO_OP_MAG || instr_q[31:26] == AAAO_OP_NEG_MAG;
	// Every word is captured; it only means something while exec_q is set.
	always_ff @(posedge clk) begin
		if (reset) begin
			exec_q <= 1'b0;
			instr_q <= DATA_RST;
		end else begin
			exec_q <= exec_d;
			instr_q <= pwdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("No answer after the wait state.");
	chk_wb_cause: assert property (wb_valid |-> exec_q && instr_q[RQ_BIT])
		else $error("Write-back without a writing instruction.");
	chk_wb_suppress: assert property (exec_q && !instr_q[RQ_BIT] |-> !wb_valid)
		else $error("Write-back despite suppressed result.");
	chk_imm_mag: assert property (imm_q && instr_q[RQ_BIT]
		&& instr_q[31:26] == AAAO_OP_MAG |-> wb_data == imm_x)
		else $error("Immediate magnitude result wrong.");
	chk_imm_neg: assert property (imm_q && instr_q[RQ_BIT]
		&& instr_q[31:26] == AAAO_OP_NEG_MAG |-> wb_data == -imm_x)
		else $error("Immediate negated magnitude wrong.");
	chk_imm_zero: assert property (imm_q && instr_q[ZQ_BIT] && mag_q
		|-> zero_flag == (imm_x == DATA_RST))
		else $error("Zero flag wrong for immediate source.");
	chk_imm_carry: assert property (imm_q && instr_q[CQ_BIT] && mag_q |-> !carry_flag)
		else $error("Carry set for an immediate source.");
	chk_flag_hold: assert property (exec_q |-> (instr_q[ZQ_BIT] || $stable(zero_flag))
		&& (instr_q[CQ_BIT] || $stable(carry_flag)))
		else $error("Flag changed without its qualifier.");
endmodule
bind aaao_top aaao_top_sva chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.wb_valid(wb_valid), .wb_data(wb_data), .zero_flag(zero_flag), .carry_flag(carry_flag));

// ==== verification/tb_abs_and_add_alu_ops.sv ====
`timescale 1ns/100ps
module tb_abs_and_add_alu_ops;
	import aaao_pkg::*;
	// ----------------------------------------------------------------
	// Signals, clock and instances
	// ----------------------------------------------------------------
	localparam logic [8:0] DST = 9'h1A5;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] wb_data;
	logic [8:0] wb_addr;
	logic pready, pslverr, wb_valid, zero_flag, carry_flag;
	logic [31:0] rd;
	logic er;
	int n_errors = 0;
	int num_checks = 0;
	// Half period of 10 ns gives the 50 MHz core clock.
	always #10 clk = ~clk;
	aaao_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data), .zero_flag(zero_flag),
		.carry_flag(carry_flag));
	aaao_rf_model rf (.clk(clk), .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data));
	// ----------------------------------------------------------------
	// Bus, compare and closing tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] iw(input logic [5:0] op, input logic [3:0] q,
		input logic [8:0] s);
		return {op, q, 4'hF, DST, s};
	endfunction
	// The request is held until pready is seen high, never assuming a latency.
	// Only the watchdog ends a wait that never completes.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			n_errors++;
		end
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Register source, both flag updates, result written to DST.
	task automatic row(input logic [5:0] op, input logic [31:0] d, s, res, input logic z, c);
		bus(1'b1, REG_DEST_OPND, d);
		bus(1'b1, REG_SRC_OPND, s);
		bus(1'b1, REG_INSTR, iw(op, 4'b1110, 9'h000));
		bus(1'b0, REG_RESULT, 32'h0000_0000);
		chk(rd, res);
		bus(1'b0, REG_FLAGS, 32'h0000_0000);
		chk(rd, {30'h0000_0000, c, z});
		chk({30'h0000_0000, carry_flag, zero_flag}, {30'h0000_0000, c, z});
		chk(rf.mem[DST], res);
	endtask
	// Suppressed result with only the zero update: D stays, carry holds.
	task automatic t_suppress();
		bus(1'b1, REG_FLAGS, 32'h0000_0000);
		bus(1'b1, REG_DEST_OPND, 32'hFFFF_FFFE);
		bus(1'b1, REG_SRC_OPND, 32'h0000_0002);
		bus(1'b1, REG_INSTR, iw(AAAO_OP_SUM, 4'b1000, 9'h000));
		bus(1'b0, REG_DEST_OPND, 32'h0000_0000);
		chk(rd, 32'hFFFF_FFFE);
		bus(1'b0, REG_FLAGS, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
	endtask
	// Immediate field differs from the register so the wrong pick shows.
	task automatic t_imm();
		bus(1'b1, REG_SRC_OPND, 32'hFFFF_FFFF);
		bus(1'b1, REG_INSTR, iw(AAAO_OP_MAG, 4'b1111, 9'h1FF));
		bus(1'b0, REG_RESULT, 32'h0000_0000);
		chk(rd, 32'h0000_01FF);
		bus(1'b1, REG_INSTR, iw(AAAO_OP_NEG_MAG, 4'b1111, 9'h1FF));
		bus(1'b0, REG_RESULT, 32'h0000_0000);
		chk(rd, 32'hFFFF_FE01);
		bus(1'b0, REG_FLAGS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		bus(1'b0, REG_WB_ADDR, 32'h0000_0000);
		chk(rd, {23'h00_0000, DST});
	endtask
	// Reset values, unmapped and read-only places, and an unknown opcode.
	task automatic t_refuse();
		bus(1'b0, REG_FLAGS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		bus(1'b0, 8'h40, 32'h0000_0000);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		bus(1'b1, REG_RESULT, 32'h1234_5678);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		bus(1'b1, REG_INSTR, iw(6'b000000, 4'b1110, 9'h000));
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk({31'h0000_0000, rd[ST_BADOP_BIT]}, 32'h0000_0001);
		// Writing ones clears both sticky status bits.
		bus(1'b1, REG_STATUS, 32'h0000_0003);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
	endtask
	// Main sequence; the watchdog cuts a hang short after 5000 cycles.
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_refuse();
		row(AAAO_OP_MAG, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b1, 1'b0);
		row(AAAO_OP_MAG, 32'h0000_0000, 32'h8000_0001, 32'h7FFF_FFFF, 1'b0, 1'b1);
		row(AAAO_OP_MAG, 32'h0000_0000, 32'h8000_0000, 32'h8000_0000, 1'b0, 1'b1);
		row(AAAO_OP_NEG_MAG, 32'h0000_0000, 32'h7FFF_FFFF, 32'h8000_0001, 1'b0, 1'b0);
		row(AAAO_OP_NEG_MAG, 32'h0000_0000, 32'h8000_0000, 32'h8000_0000, 1'b0, 1'b1);
		row(AAAO_OP_SUM, 32'hFFFF_FFFE, 32'h0000_0002, 32'h0000_0000, 1'b1, 1'b1);
		row(AAAO_OP_SUM, 32'hFFFF_FFFE, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0, 1'b0);
		row(AAAO_OP_SUM_MAG, 32'hFFFF_FFFD, 32'h0000_0003, 32'h0000_0000, 1'b1, 1'b1);
		row(AAAO_OP_SUM_MAG, 32'hFFFF_FFFD, 32'hFFFF_FFFF, 32'hFFFF_FFFE, 1'b0, 1'b1);
		row(AAAO_OP_SUM_MAG, 32'hFFFF_FFFD, 32'hFFFF_FFFC, 32'h0000_0001, 1'b0, 1'b0);
		row(AAAO_OP_SIGNED_SUM, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0000, 1'b1, 1'b0);
		row(AAAO_OP_SIGNED_SUM, 32'h7FFF_FFFE, 32'h0000_0002, 32'h8000_0000, 1'b0, 1'b1);
		row(AAAO_OP_SUM, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b1, 1'b0);
		t_suppress();
		t_imm();
		conclude();
	end
	initial begin
		#(5000 * 20);
		n_errors++;
		conclude();
	end
endmodule
